// *** core/pmc_pkg.sv ***
// Package: constants and types shared by the power manager files
package pmc_pkg;

  // ----------------------------------------------------------------
  // Prescaler sizing and reset values
  // ----------------------------------------------------------------
  localparam int           PMC_PRESC_W   = 3;       // Divide code width, ratio is 2**code
  localparam int           PMC_CNT_W     = 6;       // Counter width, slowest ratio 1/64
  localparam logic [2:0]   PMC_PRESC_MAX = 3'h6;    // Code for 1/64 of normal rate
  localparam logic [2:0]   PMC_PRESC_RST = 3'h0;    // Undivided after reset
  localparam logic [5:0]   PMC_CNT_RST   = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_POWERSAVE,
    PMC_IDLE,
    PMC_POWERDOWN
  } pmc_mode_e;

  typedef struct packed {
    logic                   idle;
    logic                   powerdown;
    logic                   powersave;
    logic [PMC_PRESC_W-1:0] prescale;
  } pmc_ctrl_s;

  localparam pmc_ctrl_s PMC_CTRL_RST = '{idle: 1'b0, powerdown: 1'b0,
                                         powersave: 1'b0, prescale: PMC_PRESC_RST};

endpackage : pmc_pkg

// *** core/pmc_prescaler.sv ***
// Prescaler: emits a tick each time the internal clock phase must flip
`timescale 1ns/10ps
module pmc_prescaler
  import pmc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   restart,
  input  wire logic [PMC_PRESC_W-1:0] code,
  output logic                        tick
);

  // ----------------------------------------------------------------
  // Mask of counter bits that must be ones for a tick
  // ----------------------------------------------------------------
  logic [PMC_CNT_W-1:0] cnt;
  logic [PMC_CNT_W-1:0] mask;

  genvar gi;
  generate
    for (gi = 0; gi < PMC_CNT_W; gi++) begin : g_mask
      // Code n sets the low n bits, tick every 2**n cycles
      assign mask[gi] = (3'(gi) < code);
    end
  endgenerate

  assign tick = ((cnt & mask) == mask);

  // Free counter, cleared on restart so a new ratio starts clean
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt <= PMC_CNT_RST;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end

endmodule : pmc_prescaler

// *** core/pmc_power_manager.sv ***
// Power manager: derives, divides and gates the internal clocks
//
// Operation
// [R1] Four modes exist: Active, Powersave, Idle and Powerdown, chosen by the control inputs.
// [R2] In Active every unit is clocked at half the input clock rate.
// [R3] In Idle the execution and bus clocks sit at zero while peripheral clocks keep running.
// [R4] In Powerdown every internal clock stops at zero.
// [R5] Entering Powerdown also turns off the crystal oscillator drive.
// [R6] Powersave divides all internal clocks by a prescaler, down to one sixty-fourth.
// [R7] Powersave may be combined with Idle or Active, dividing whatever clocks still run.
// [R8] The output clock runs at half the input clock with an even duty cycle; the code divides it in powersave and holds it low in powerdown.
// [R9] Gating and ratio changes take effect only while the internal clock is low.
`timescale 1ns/10ps
module pmc_power_manager
  import pmc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  pmc_ctrl_s                   mode_req,
  output logic                        output_clock_pin,
  output logic                        cpu_clk,
  output logic                        bus_clk,
  output logic                        periph_clk,
  output logic                        crystal_drive_en,
  output pmc_mode_e                   mode_status,
  output logic [PMC_PRESC_W-1:0]      prescale_status
);

  // ----------------------------------------------------------------
  // Applied settings and phase
  // ----------------------------------------------------------------
  pmc_ctrl_s              applied;
  pmc_ctrl_s              next_applied;
  pmc_ctrl_s              req_clean;
  logic                   int_clk;
  logic                   next_int_clk;
  logic                   tick;
  logic                   load;
  logic                   core_run;
  logic                   periph_run;
  pmc_mode_e              next_mode;

  // Clamp ratio; no powersave means undivided
  always_comb begin
    req_clean = mode_req;
    if (!mode_req.powersave) begin
      req_clean.prescale = PMC_PRESC_RST;
    end else if (mode_req.prescale > PMC_PRESC_MAX) begin
      req_clean.prescale = PMC_PRESC_MAX;                        // see [R6]
    end
  end

  // Settings load only as the phase falls, or while frozen low
  assign load         = (int_clk && tick) || (!int_clk && applied.powerdown); // see [R9]
  assign next_applied = load ? req_clean : applied;

  // Phase flips on each tick; frozen low in powerdown
  always_comb begin
    if (applied.powerdown && !int_clk) begin
      next_int_clk = 1'b0;                                       // see [R4]
    end else if (tick) begin
      next_int_clk = ~int_clk;                                   // see [R8]
    end else begin
      next_int_clk = int_clk;
    end
  end

  // Run enables only change with the phase low, so no runt pulses
  assign core_run   = !next_applied.idle && !next_applied.powerdown; // see [R3]
  assign periph_run = !next_applied.powerdown;                       // see [R4]

  // Reported mode; idle wins over powersave in the report
  always_comb begin
    if (next_applied.powerdown) begin
      next_mode = PMC_POWERDOWN;
    end else if (next_applied.idle) begin
      next_mode = PMC_IDLE;
    end else if (next_applied.powersave) begin
      next_mode = PMC_POWERSAVE;
    end else begin
      next_mode = PMC_ACTIVE;                                    // see [R1]
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, restarted at each load so a new ratio begins whole
  // ----------------------------------------------------------------
  // Ratio in force, never the pending one: tick would feed back into load
  pmc_prescaler u_presc (
    .clk     (clk),
    .rst     (rst),
    .restart (load),
    .code    (applied.prescale),                                 // see [R7]
    .tick    (tick)
  );

  // Settings and phase state
  always_ff @(posedge clk) begin
    if (rst) begin
      applied <= PMC_CTRL_RST;
      int_clk <= 1'b0;
    end else begin
      applied <= next_applied;
      int_clk <= next_int_clk;
    end
  end

  // Registered clock and status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      output_clock_pin <= 1'b0;
      cpu_clk          <= 1'b0;
      bus_clk          <= 1'b0;
      periph_clk       <= 1'b0;
      crystal_drive_en <= 1'b1;
      mode_status      <= PMC_ACTIVE;
      prescale_status  <= PMC_PRESC_RST;
    end else begin
      output_clock_pin <= next_int_clk;                          // see [R8]
      cpu_clk          <= next_int_clk && core_run;              // see [R2]
      bus_clk          <= next_int_clk && core_run;              // see [R3]
      periph_clk       <= next_int_clk && periph_run;            // see [R7]
      crystal_drive_en <= !next_applied.powerdown;               // see [R5]
      mode_status      <= next_mode;
      prescale_status  <= next_applied.prescale;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_active_two;
    (mode_status == PMC_ACTIVE) ##1 (mode_status == PMC_ACTIVE);
  endsequence

  property p_active_half;
    @(posedge clk) disable iff (rst)
    s_active_two |-> (output_clock_pin != $past(output_clock_pin));
  endproperty
  a_active_half: assert property (p_active_half) // see [R2]
    else $error("Active clock did not toggle every input cycle");

  property p_core_follows_pin;
    @(posedge clk) disable iff (rst)
    (cpu_clk || bus_clk || periph_clk) |-> output_clock_pin;
  endproperty
  a_core_follows_pin: assert property (p_core_follows_pin) // see [R8]
    else $error("Unit clock high while output clock low");

  property p_idle_core_low;
    @(posedge clk) disable iff (rst)
    (mode_status == PMC_IDLE) |-> (!cpu_clk && !bus_clk);
  endproperty
  a_idle_core_low: assert property (p_idle_core_low) // see [R3]
    else $error("Core clock ran in idle");

  sequence s_idle_fast;
    (mode_status == PMC_IDLE && prescale_status == PMC_PRESC_RST) [*2];
  endsequence

  property p_idle_periph_runs;
    @(posedge clk) disable iff (rst)
    s_idle_fast |-> (periph_clk != $past(periph_clk));
  endproperty
  a_idle_periph_runs: assert property (p_idle_periph_runs) // see [R3]
    else $error("Peripheral clock stalled in idle");

  property p_pd_all_low;
    @(posedge clk) disable iff (rst)
    (mode_status == PMC_POWERDOWN) |-> (!cpu_clk && !bus_clk && !periph_clk);
  endproperty
  a_pd_all_low: assert property (p_pd_all_low) // see [R4]
    else $error("Clock ran in powerdown");

  property p_pd_osc_off;
    @(posedge clk) disable iff (rst)
    (mode_status == PMC_POWERDOWN) == !crystal_drive_en;
  endproperty
  a_pd_osc_off: assert property (p_pd_osc_off) // see [R5]
    else $error("Crystal drive disagrees with powerdown");

  sequence s_slow_rise;
    $rose(periph_clk) && (prescale_status == PMC_PRESC_MAX);
  endsequence

  property p_slow_high;
    @(posedge clk) disable iff (rst)
    s_slow_rise |-> periph_clk [*8];
  endproperty
  a_slow_high: assert property (p_slow_high) // see [R6]
    else $error("Slowest ratio gave a short high phase");

  property p_ratio_low_change;
    @(posedge clk) disable iff (rst)
    ($changed(mode_status) || $changed(prescale_status)) |-> !output_clock_pin;
  endproperty
  a_ratio_low_change: assert property (p_ratio_low_change) // see [R9]
    else $error("Setting changed while clock high");

  property p_no_runt;
    @(posedge clk) disable iff (rst)
    $fell(cpu_clk) |-> !output_clock_pin;
  endproperty
  a_no_runt: assert property (p_no_runt) // see [R9]
    else $error("Core clock cut short while phase high");

  property p_pd_pin_low;
    @(posedge clk) disable iff (rst)
    (mode_status == PMC_POWERDOWN) |-> !output_clock_pin;
  endproperty
  a_pd_pin_low: assert property (p_pd_pin_low) // see [R4]
    else $error("Output clock ran in powerdown");

  // Any running mode at the full rate flips the pin every cycle
  sequence s_fast_run;
    (mode_status != PMC_POWERDOWN && prescale_status == PMC_PRESC_RST) [*2];
  endsequence

  property p_duty_even;
    @(posedge clk) disable iff (rst)
    s_fast_run |-> $changed(output_clock_pin);
  endproperty
  a_duty_even: assert property (p_duty_even) // see [R8]
    else $error("Undivided clock missed a phase");

  // A fall into the slowest ratio must be followed by a long low phase
  sequence s_slow_fall;
    $fell(periph_clk) && (prescale_status == PMC_PRESC_MAX);
  endsequence

  property p_slow_low;
    @(posedge clk) disable iff (rst)
    s_slow_fall |-> (!periph_clk) [*8];
  endproperty
  a_slow_low: assert property (p_slow_low) // see [R6]
    else $error("Slowest ratio gave a short low phase");

endmodule : pmc_power_manager

// *** verification/pmc_clock_source.sv ***
// Partner model: external oscillator feeding the input clock pin
`timescale 1ns/10ps
module pmc_clock_source #(
  parameter time HALF_NS = 20
) (
  output logic clk
);
  // Free running source, so it keeps going while the crystal drive is off
  initial clk = 1'b0;
  always #(HALF_NS) clk = ~clk;
endmodule : pmc_clock_source

// *** verification/pmc_power_manager_tb.sv ***
// Testbench: mode selection, gating and prescaler checks for the power manager
`timescale 1ns/10ps
module pmc_power_manager_tb;
  import pmc_pkg::*;
  logic                   clk;
  logic                   rst;
  pmc_ctrl_s              mode_req;
  logic                   ocp, cpu_clk, bus_clk, periph_clk, xtal;
  pmc_mode_e              mode_status;
  logic [PMC_PRESC_W-1:0] prescale_status;
  int                     mismatches;
  int                     checks_done;
  int                     cycles = 0;

  pmc_clock_source u_clk (.clk(clk));
  pmc_power_manager u_dut (.clk(clk), .rst(rst), .mode_req(mode_req),
    .output_clock_pin(ocp), .cpu_clk(cpu_clk), .bus_clk(bus_clk),
    .periph_clk(periph_clk), .crystal_drive_en(xtal),
    .mode_status(mode_status), .prescale_status(prescale_status));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Requests a mode, waits for it, then counts levels and edges over 4 phases
  task automatic run_mode(input logic i, p, s, input logic [2:0] c,
                          input pmc_mode_e em, input logic cpu_on, per_on);
    int         k, len, w, hi_o, hi_c, hi_b, hi_p, tr_o, tr_c, tr_p;
    logic [2:0] ec;
    logic       lo, lc, lp;
    ec = s ? ((c > PMC_PRESC_MAX) ? PMC_PRESC_MAX : c) : PMC_PRESC_RST;
    len = 1 << ec;
    w = 4 * len;
    hi_o = 0;
    hi_c = 0;
    hi_b = 0;
    hi_p = 0;
    tr_o = 0;
    tr_c = 0;
    tr_p = 0;
    mode_req = '{idle: i, powerdown: p, powersave: s, prescale: c};
    k = 0;
    // Bounded wait, the load happens only at a falling phase or while frozen low in powerdown
    while ((mode_status !== em || prescale_status !== ec) && k < 300) begin
      @(posedge clk);
      #2;
      k++;
    end
    chk(16'(mode_status), 16'(em));
    chk(16'(prescale_status), 16'(ec));
    // One whole period first, so counting starts in steady state
    repeat (2 * len) @(posedge clk);
    #2;
    lo = ocp;
    lc = cpu_clk;
    lp = periph_clk;
    for (k = 0; k < w; k++) begin
      @(posedge clk);
      #2;
      hi_o += (ocp === 1'b1);
      hi_c += (cpu_clk === 1'b1);
      hi_b += (bus_clk === 1'b1);
      hi_p += (periph_clk === 1'b1);
      tr_o += (ocp !== lo);
      tr_c += (cpu_clk !== lc);
      tr_p += (periph_clk !== lp);
      lo = ocp;
      lc = cpu_clk;
      lp = periph_clk;
      chk(16'(xtal), 16'(!p));
      chk(16'({cpu_clk & ~ocp, bus_clk & ~ocp, periph_clk & ~ocp}), 16'h0000);
    end
    chk(16'(hi_o), 16'(per_on ? w / 2 : 0));
    chk(16'(tr_o), 16'(per_on ? w / len : 0));
    chk(16'(hi_p), 16'(per_on ? w / 2 : 0));
    chk(16'(tr_p), 16'(per_on ? w / len : 0));
    chk(16'(hi_c), 16'(cpu_on ? w / 2 : 0));
    chk(16'(hi_b), 16'(cpu_on ? w / 2 : 0));
    chk(16'(tr_c), 16'(cpu_on ? w / len : 0));
  endtask : run_mode

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Holds reset 4 cycles, then checks the first two edges after release
  task automatic t_reset();
    rst = 1'b1;
    mode_req = PMC_CTRL_RST;
    repeat (4) @(posedge clk);
    #2;
    chk(16'({ocp, cpu_clk, bus_clk, periph_clk, xtal}), 16'h0001);
    chk(16'(mode_status), 16'(PMC_ACTIVE));
    chk(16'(prescale_status), 16'(PMC_PRESC_RST));
    rst = 1'b0;
    @(posedge clk);
    #2;
    chk(16'({ocp, cpu_clk, bus_clk, periph_clk, xtal}), 16'h001f);
    @(posedge clk);
    #2;
    chk(16'({ocp, cpu_clk, bus_clk, periph_clk, xtal}), 16'h0001);
  endtask : t_reset

  task automatic t_active_idle();
    run_mode(1'b0, 1'b0, 1'b0, PMC_PRESC_RST, PMC_ACTIVE, 1'b1, 1'b1);
    run_mode(1'b1, 1'b0, 1'b0, PMC_PRESC_RST, PMC_IDLE, 1'b0, 1'b1);
  endtask : t_active_idle

  // Idle is requested too, powerdown must still win; last exit is by reset
  task automatic t_powerdown();
    run_mode(1'b1, 1'b1, 1'b0, PMC_PRESC_RST, PMC_POWERDOWN, 1'b0, 1'b0);
    run_mode(1'b0, 1'b0, 1'b0, PMC_PRESC_RST, PMC_ACTIVE, 1'b1, 1'b1);
    run_mode(1'b0, 1'b1, 1'b1, 3'h3, PMC_POWERDOWN, 1'b0, 1'b0);
    t_reset();
  endtask : t_powerdown

  // Every code, including one past the slowest that must clamp
  task automatic t_powersave();
    for (int c = 0; c < 8; c++) begin
      run_mode(1'b0, 1'b0, 1'b1, 3'(c), PMC_POWERSAVE, 1'b1, 1'b1);
    end
  endtask : t_powersave

  task automatic t_idle_divided();
    run_mode(1'b1, 1'b0, 1'b1, 3'h2, PMC_IDLE, 1'b0, 1'b1);
    run_mode(1'b1, 1'b0, 1'b1, 3'h6, PMC_IDLE, 1'b0, 1'b1);
    run_mode(1'b0, 1'b0, 1'b0, PMC_PRESC_RST, PMC_ACTIVE, 1'b1, 1'b1);
  endtask : t_idle_divided

  // Hang guard, the full run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    mismatches = 0;
    checks_done = 0;
    t_reset();
    t_active_idle();
    t_powerdown();
    t_powersave();
    t_idle_divided();
    print_verdict();
  end
endmodule : pmc_power_manager_tb
